// [include/gatoc_pkg.sv]
// Constants and types for the remote-interface configuration block.
// Assumes a 50 MHz system clock and a synchronous active-low reset.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package gatoc_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int FLASH_MS = 500;
  localparam int FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
  localparam int ADDR_W = 5;
  localparam int FUNC_W = 8;
  localparam logic [FUNC_W-1:0] FUNC_POWER = 8'h01;
  localparam logic [FUNC_W-1:0] FUNC_STANDBY = 8'h02;
  localparam logic [FUNC_W-1:0] FUNC_TRIG_LEVEL = 8'h04;
  localparam logic [FUNC_W-1:0] FUNC_LOCAL_ONLY = FUNC_POWER | FUNC_STANDBY | FUNC_TRIG_LEVEL;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;
  localparam logic [3:0] TENS_MAX = 4'h3;
  localparam logic [ADDR_W-1:0] TEN = 5'h0A;

  typedef enum logic [1:0] {
    GATOC_KEY_IDLE = 2'b00,
    GATOC_KEY_RECALL = 2'b01,
    GATOC_KEY_SHOW = 2'b11
  } gatoc_key_e;
endpackage : gatoc_pkg

// [include/gatoc_sw_if.sv]
// Switch bundle passed from the synchroniser to the control logic.
// Assumes one clock domain.
`timescale 1ns/1ns
interface gatoc_sw_if;
  logic [4:0] addr;
  logic talk_only;
  modport src (output addr, output talk_only);
  modport dst (input addr, input talk_only);
endinterface : gatoc_sw_if

// [verilog/gatoc_sync.sv]
// Two-flop synchroniser for the rear-panel switches.
// Assumes raw switch levels are asynchronous to clock_in.
`timescale 1ns/1ns
module gatoc_sync (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Raw switches
  input wire logic [4:0] sw_addr_in,
  input wire logic sw_talk_only_in,
  // Synchronised switches
  gatoc_sw_if.src sw
);
  import gatoc_pkg::*;
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
  } gatoc_sync_s;
  gatoc_sync_s st_ff;
  gatoc_sync_s nxt_st;

  always_comb begin
    nxt_st.s1 = {sw_talk_only_in, sw_addr_in};
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sw.addr = st_ff.s2[4:0];
  assign sw.talk_only = st_ff.s2[5];
endmodule : gatoc_sync

// [verilog/gatoc_top.sv]
// Remote-interface configuration: address, talk-only, address display, indicators.
// Assumes key inputs are one-cycle pulses from a same-clock keypad decoder.
`timescale 1ns/1ns
module gatoc_top (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Rear-panel switches (asynchronous)
  input wire logic address_switch_bit_low_in,
  input wire logic [2:0] address_switch_mid_in,
  input wire logic address_switch_bit_high_in,
  input wire logic talk_only_switch_in,
  // Front-panel keys, one-cycle pulses; lamp test is a level, indicators lit while it is high
  input wire logic key_recall_in,
  input wire logic key_local_in,
  input wire logic key_continue_in,
  input wire logic key_other_in,
  input wire logic lamp_test_in,
  // Interface status from bus logic
  input wire logic remote_state_in,
  input wire logic addressed_state_in,
  input wire logic srq_state_in,
  // Remote function request
  input wire logic [gatoc_pkg::FUNC_W-1:0] remote_func_req_in,
  // Outputs
  output logic [gatoc_pkg::ADDR_W-1:0] bus_address_out,
  output logic addressed_mode_out,
  output logic talk_only_mode_out,
  output logic [gatoc_pkg::FUNC_W-1:0] remote_func_grant_out,
  output logic addr_display_out,
  output logic [3:0] disp_tens_out,
  output logic [3:0] disp_units_out,
  output logic remote_indicator_out,
  output logic addressed_indicator_out,
  output logic srq_indicator_out
);
  import gatoc_pkg::*;

  typedef struct packed {
    gatoc_key_e key;
    logic [ADDR_W-1:0] addr;
    logic talk_only;
    logic addressed;
    logic show;
    logic [FUNC_W-1:0] grant;
    logic [3:0] tens;
    logic [3:0] units;
    logic [1:0] flash_ph;
    logic [31:0] flash_cnt;
    logic ind_rem;
    logic ind_addr;
    logic ind_srq;
  } gatoc_top_s;

  gatoc_top_s st_ff;
  gatoc_top_s nxt_st;

  gatoc_sw_if sw ();

  gatoc_sync u_sync (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .sw_addr_in({address_switch_bit_high_in, address_switch_mid_in, address_switch_bit_low_in}),
    .sw_talk_only_in(talk_only_switch_in),
    .sw(sw.src)
  );

  logic flashing;
  logic [ADDR_W-1:0] live_addr;
  logic [ADDR_W-1:0] remote_indicator;

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    flashing = (st_ff.flash_ph != 2'b00);
    live_addr = sw.addr;
    remote_indicator = live_addr;
    nxt_st.addr = sw.talk_only ? ADDR_RESET : live_addr;
    nxt_st.talk_only = sw.talk_only;
    nxt_st.addressed = ~sw.talk_only;
    nxt_st.grant = remote_func_req_in & ~FUNC_LOCAL_ONLY;

    unique case (st_ff.key)
      GATOC_KEY_IDLE: begin
        if (key_recall_in) begin
          nxt_st.key = GATOC_KEY_RECALL;
        end
      end
      GATOC_KEY_RECALL: begin
        if (key_local_in) begin
          nxt_st.key = GATOC_KEY_SHOW;
          nxt_st.tens = 4'h0;
          for (int i = 0; i < 3; i++) begin
            if (remote_indicator >= TEN) begin
              remote_indicator = remote_indicator - TEN;
              nxt_st.tens = nxt_st.tens + 4'h1;
            end
          end
          nxt_st.units = {1'b0, remote_indicator[2:0]} + {remote_indicator[3], 3'b000};
        end else if (key_recall_in) begin
          nxt_st.key = GATOC_KEY_RECALL;
        end else if (key_continue_in || key_other_in) begin
          nxt_st.key = GATOC_KEY_IDLE;
        end
      end
      GATOC_KEY_SHOW: begin
        if (key_continue_in) begin
          nxt_st.key = GATOC_KEY_IDLE;
        end else if (key_recall_in) begin
          nxt_st.key = GATOC_KEY_RECALL;
        end
      end
      default: begin
        nxt_st.key = GATOC_KEY_IDLE;
      end
    endcase
    nxt_st.show = (nxt_st.key == GATOC_KEY_SHOW);

    if (flashing) begin
      if (st_ff.flash_cnt == 32'(FLASH_CYC - 1)) begin
        nxt_st.flash_cnt = '0;
        nxt_st.flash_ph = (st_ff.flash_ph == 2'b01) ? 2'b10 : 2'b00;
      end else begin
        nxt_st.flash_cnt = st_ff.flash_cnt + 32'd1;
      end
    end

    if (lamp_test_in) begin
      nxt_st.ind_rem = 1'b1;
      nxt_st.ind_addr = 1'b1;
      nxt_st.ind_srq = 1'b1;
    end else if (flashing) begin
      nxt_st.ind_rem = (st_ff.flash_ph == 2'b01);
      nxt_st.ind_addr = (st_ff.flash_ph == 2'b01);
      nxt_st.ind_srq = (st_ff.flash_ph == 2'b01);
    end else begin
      nxt_st.ind_rem = remote_state_in;
      nxt_st.ind_addr = addressed_state_in & ~st_ff.talk_only;
      nxt_st.ind_srq = srq_state_in;
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      st_ff.key <= GATOC_KEY_IDLE;
      st_ff.addr <= ADDR_RESET;
      st_ff.talk_only <= 1'b0;
      st_ff.addressed <= 1'b1;
      st_ff.show <= 1'b0;
      st_ff.grant <= '0;
      st_ff.tens <= 4'h0;
      st_ff.units <= 4'h0;
      st_ff.flash_ph <= 2'b01;
      st_ff.flash_cnt <= '0;
      st_ff.ind_rem <= 1'b0;
      st_ff.ind_addr <= 1'b0;
      st_ff.ind_srq <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus_address_out = st_ff.addr;
  assign addressed_mode_out = st_ff.addressed;
  assign talk_only_mode_out = st_ff.talk_only;
  assign remote_func_grant_out = st_ff.grant;
  assign addr_display_out = st_ff.show;
  assign disp_tens_out = st_ff.tens;
  assign disp_units_out = st_ff.units;
  assign remote_indicator_out = st_ff.ind_rem;
  assign addressed_indicator_out = st_ff.ind_addr;
  assign srq_indicator_out = st_ff.ind_srq;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  a_func_local_only: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (remote_func_grant_out & FUNC_LOCAL_ONLY) == '0) else $error("local-only function granted");
  a_addr_follow_sw: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !sw.talk_only |=> bus_address_out == $past(sw.addr))
    else $error("address not from switches");
  a_disp_show: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    st_ff.key == GATOC_KEY_RECALL && key_local_in |=> addr_display_out) else $error("display not entered");
  a_disp_frozen: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    addr_display_out && $past(addr_display_out) |-> $stable(disp_tens_out) && $stable(disp_units_out))
    else $error("shown address changed");
  a_disp_value: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    st_ff.key == GATOC_KEY_RECALL && key_local_in |=>
    (disp_tens_out * 10 + disp_units_out) == $past(sw.addr)) else $error("decimal value wrong");
  a_cont_exit: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    addr_display_out && key_continue_in |=> !addr_display_out) else $error("continue ignored");
  a_mode_addr: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    addressed_mode_out != talk_only_mode_out) else $error("mode outputs inconsistent");
  a_talk_ignore: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    talk_only_mode_out |-> bus_address_out == ADDR_RESET)
    else $error("talk-only uses address");
  a_talk_no_ind: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    st_ff.talk_only && !lamp_test_in && st_ff.flash_ph == 2'b00 |=> !addressed_indicator_out)
    else $error("addressed indicator in talk-only");
  a_lamp_steady: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    lamp_test_in |=> remote_indicator_out && addressed_indicator_out && srq_indicator_out)
    else $error("lamp test indicators not lit");
  a_flash_once: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    st_ff.flash_ph == 2'b00 |=> st_ff.flash_ph == 2'b00) else $error("flash restarted");
  a_flash_order: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    st_ff.flash_ph == 2'b10 |=> st_ff.flash_ph != 2'b01) else $error("flash phase repeated");
endmodule : gatoc_top

// [tb/gatoc_ctl_model.sv]
// Behavioural stand-in for the bus controller and the bus logic behind it.
// Assumes one clock; status lines step through a 3-bit count every cycle to stress the indicators.
`timescale 1ns/1ns
module gatoc_ctl_model (
  // Clock
  input wire logic clock_in,
  // Function request from the bench
  input wire logic [7:0] cmd_in,
  // Towards the block
  output logic [7:0] func_req_out,
  output logic remote_out,
  output logic addressed_out,
  output logic srq_out
);
  logic [2:0] cnt_ff = 3'h0;
  always @(posedge clock_in) begin
    cnt_ff <= cnt_ff + 3'h1;
  end
  assign {remote_out, addressed_out, srq_out} = cnt_ff;
  assign func_req_out = cmd_in;
endmodule : gatoc_ctl_model

// [tb/gpib_address_talk_only_config_test.sv]
// Self-checking bench for the remote-interface configuration block.
// Assumes the design package and the controller model are compiled first.
`timescale 1ns/1ns
module gpib_address_talk_only_config_test;
  import gatoc_pkg::*;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [4:0] sw_a = 5'h00;
  logic sw_t = 1'b0;
  logic k_rec = 1'b0, k_loc = 1'b0, k_con = 1'b0, k_oth = 1'b0, lamp = 1'b0;
  logic [7:0] cmd = 8'h00;
  logic [7:0] req, grant;
  logic remote_indicator, adr, srq, am, tm, disp, ri, ai, si;
  logic [4:0] bus_addr;
  logic [3:0] tens, units;
  int fail_count = 0, n_compared = 0, cyc = 0, a, t, r;
  // ----------------------------------------
  // Clock, instances
  // ----------------------------------------
  always #10 clock_in = ~clock_in;
  gatoc_ctl_model u_ctl (.clock_in(clock_in), .cmd_in(cmd), .func_req_out(req), .remote_out(remote_indicator),
    .addressed_out(adr), .srq_out(srq));
  gatoc_top u_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .address_switch_bit_low_in(sw_a[0]),
    .address_switch_mid_in(sw_a[3:1]), .address_switch_bit_high_in(sw_a[4]), .talk_only_switch_in(sw_t),
    .key_recall_in(k_rec), .key_local_in(k_loc), .key_continue_in(k_con), .key_other_in(k_oth),
    .lamp_test_in(lamp), .remote_state_in(remote_indicator), .addressed_state_in(adr), .srq_state_in(srq),
    .remote_func_req_in(req), .bus_address_out(bus_addr), .addressed_mode_out(am), .talk_only_mode_out(tm),
    .remote_func_grant_out(grant), .addr_display_out(disp), .disp_tens_out(tens), .disp_units_out(units),
    .remote_indicator_out(ri), .addressed_indicator_out(ai), .srq_indicator_out(si));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : tick
  task key(input int which);
    @(posedge clock_in);
    k_rec <= (which == 0);
    k_loc <= (which == 1);
    k_con <= (which == 2);
    k_oth <= (which == 3);
    @(posedge clock_in);
    {k_rec, k_loc, k_con, k_oth} <= 4'b0000;
  endtask : key
  task set_sw(input int av, input int tv);
    @(posedge clock_in);
    sw_a <= av[4:0];
    sw_t <= tv[0];
    tick(4);
  endtask : set_sw
  // ----------------------------------------
  // Timeout
  // ----------------------------------------
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h183ecd65));
    repeat (16) @(posedge clock_in);
    reset_n_in <= 1'b1;
    tick(3);
    chk({5'h00, ri, ai, si}, 8'h07);
    @(posedge clock_in);
    lamp <= 1'b1;
    repeat (6) begin
      tick(1);
      chk({5'h00, ri, ai, si}, 8'h07);
    end
    @(posedge clock_in);
    lamp <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 31 : $urandom % 32;
      t = (i < 2) ? i : $urandom % 2;
      set_sw(a, t);
      chk({3'h0, bus_addr}, t ? 8'h00 : 8'(a));
      chk({6'h00, am, tm}, t ? 8'h01 : 8'h02);
    end
    for (int i = 0; i < 10; i++) begin
      r = (i == 0) ? 255 : $urandom % 256;
      @(posedge clock_in);
      cmd <= r[7:0];
      tick(2);
      chk(grant, r[7:0] & ~FUNC_LOCAL_ONLY);
    end
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 31 : (i == 1) ? 9 : $urandom % 32;
      set_sw(a, 0);
      key(0);
      key(1);
      tick(1);
      chk({7'h00, disp}, 8'h01);
      chk({tens, units}, {4'(a / 10), 4'(a % 10)});
      set_sw(a ^ 31, 0);
      chk({tens, units}, {4'(a / 10), 4'(a % 10)});
      key(2);
      tick(1);
      chk({7'h00, disp}, 8'h00);
      key(0);
      key(3);
      key(1);
      tick(1);
      chk({7'h00, disp}, 8'h00);
    end
    summarize;
  end
endmodule : gpib_address_talk_only_config_test
